// *** design/khs_cfg.svh ***
`ifndef KHS_CFG_SVH
`define KHS_CFG_SVH

// Command codes
`define KHS_CMD_RESET 8'h01
`define KHS_CMD_BUSMON 8'h05
`define KHS_CMD_SYSSTAT 8'h0D
`define KHS_CMD_STOP 8'h0E
`define KHS_CMD_EXITSTOP 8'h0F
`define KHS_CMD_SETBUSY 8'h21
`define KHS_CMD_QUITBUSY 8'h22
`define KHS_CMD_SETADDR 8'hF1
`define KHS_CMD_SETREP 8'hF2
`define KHS_CMD_CFG 8'h18
`define KHS_MASK_CFG 8'hF8
`define KHS_CMD_REGWR 8'h28
`define KHS_CMD_REGRD 8'h38
`define KHS_MASK_REG 8'hFC
`define KHS_CMD_POLL 8'hE0
`define KHS_MASK_POLL 8'hF0

// Indication codes
`define KHS_IND_RESET 8'h03
`define KHS_IND_STOP 8'h2B
`define KHS_IND_SYS 8'h4B
`define KHS_IND_FEND 8'hCB
`define KHS_CON_TAIL 7'h0B
`define KHS_FST_TAIL 5'h13
`define KHS_CFG_TAIL 2'h1

// Field positions
`define KHS_REP_BSY 6:4
`define KHS_REP_NAK 2:0
`define KHS_CFG_P 2
`define KHS_CFG_C 1
`define KHS_CFG_M 0
`define KHS_ST_OK 7:3
`define KHS_ST_TW 2
`define KHS_LIM_RST 3'h3

// Timing
`define KHS_ACK_TO_BT 8'h1E
`define KHS_BUSY_IDLE_BT 8'h96
`define KHS_NACK_IDLE_BT 8'h32
`define KHS_SILENCE_MS 2.6
`define KHS_CLK_MHZ 25.0

`define KHS_CRC_POLY 16'h1021
`define KHS_CRC_INIT 16'hFFFF

// Register port
`define KHS_REG_STATUS 3'h0
`define KHS_REG_LIMITS 3'h1
`define KHS_REG_PHYS_HI 3'h2
`define KHS_REG_PHYS_LO 3'h3

// Outgoing byte sources, lowest index wins
`define KHS_SRC_BUS 0
`define KHS_SRC_DUP 1
`define KHS_SRC_CRCH 2
`define KHS_SRC_CRCL 3
`define KHS_SRC_FEND 4
`define KHS_SRC_FST 5
`define KHS_SRC_CON 6
`define KHS_SRC_CFG 7
`define KHS_SRC_SYS1 8
`define KHS_SRC_SYS2 9
`define KHS_SRC_STOP 10
`define KHS_SRC_RST 11
`define KHS_SRC_RD 12
`define KHS_NSRC 13

`endif

// *** design/khs_pkg.sv ***
`default_nettype none
package khs_pkg;
  typedef enum logic [1:0] {OP_PWRUP, OP_SYNC, OP_STOP, OP_NORMAL} khs_op_e;
  typedef enum {PS_CMD, PS_AHI, PS_ALO, PS_FILL, PS_REP, PS_WDAT,
                PS_PAHI, PS_PALO, PS_PST} khs_ps_e;
  typedef enum {R_IDLE, R_WACK, R_WIDLE} khs_rt_e;
  typedef enum logic [1:0] {ACK_POS, ACK_BUSY, ACK_NACK, ACK_BAD} khs_ack_e;
  typedef struct packed {logic vld; logic [7:0] dat;} khs_byte_s;
  typedef struct packed {logic re; logic ce; logic te;} khs_ferr_s;
  typedef struct packed {
    logic v20; logic converter_two_ok; logic bus_voltage_ok; logic tank_cap_ok; logic crystal_ok; logic tw;
  } khs_supply_s;
  typedef struct packed {
    logic busy; logic aa; logic ap; logic crc; logic mark;
  } khs_feat_s;
endpackage
`default_nettype wire

// *** design/khs_host_ctrl.sv ***
// Notes on behaviour
// - Leave-busy restores positive acks.
// - Bus monitor forwards all bus bytes; only reset exits.
// - Auto-ack acks own or group frames; errored ones get nack unless busy is set, which gives busy.
// - Address request stores address, enables auto-ack, reports once.
// - Address and auto-ack apply only on idle bus.
// - Auto-ack stays until reset; filler byte ignored.
// - Busy and nack retry limits, 3 after reset, settable.
// - Busy ack: retry after 150 idle bits, then negative.
// - Nack, bad or 30-bit timeout: retry after 50 idle bits.
// - Status returns supply, bus, tank, crystal, thermal flags.
// - Status mode: 00 power-up, 01 sync, 10 stop, 11 normal.
// - Warning pin low if any bit 7..3 zero or bit 2 one.
// - Stop request enters stop, then confirms.
// - Exit-stop goes to sync; indication on reaching normal.
// - Features off after reset; report when they take effect.
// - Feature bits only set; all zero reports configuration.
// - Auto-poll fills own slot from last polling information.
// - CRC feature appends CRC-16-CCITT to forwarded frames.
// - Frame end is 2.6 ms silence, or marker plus state.
// - Register write: address then data; read returns next byte.
// - Feature report: bit 7 zero, busy..marker in 6..2, low 01.
// - Confirmation MSB set positive, clear negative.
//
// Chosen here: the placing of the registers and the plain strobed port.
`include "khs_cfg.svh"
`default_nettype none
module khs_host_ctrl #(
  parameter int SILENCE_CYC = int'($ceil(`KHS_SILENCE_MS * `KHS_CLK_MHZ * 1000.0))
) (
  input wire logic i_mclk, // Clock 25 MHz
  input wire logic i_rst, // Sync reset, high
  input wire logic i_ce, // Clock enable
  input wire khs_pkg::khs_byte_s i_rx, // Byte from host
  output khs_pkg::khs_byte_s o_tx, // Byte to host
  input wire logic i_tx_ready, // Host link takes o_tx
  input wire khs_pkg::khs_byte_s i_bus, // Byte from bus
  input wire logic i_bus_is_ack, // Bus byte is an ack frame
  input wire logic i_frame_end, // Received frame ended
  input wire khs_pkg::khs_ferr_s i_ferr, // Frame errors at end
  input wire logic i_dst_valid, // Destination known
  input wire logic [15:0] i_dst_addr, // Destination address
  input wire logic i_dst_group, // Destination is group
  input wire logic i_bus_idle, // Bus is idle
  input wire logic i_bit_tick, // One bus bit time
  input wire logic i_sync_done, // Sync phase complete
  input wire logic i_new_frame, // New host frame to send
  input wire logic i_txf_done, // Own frame sent
  input wire logic i_ack_valid, // Ack seen for own frame
  input wire khs_pkg::khs_ack_e i_ack_kind, // Kind of that ack
  output logic o_retx_req, // Repeat own frame
  output logic o_ack_req, // Send ack on bus
  output khs_pkg::khs_ack_e o_ack_code, // Ack to send
  input wire khs_pkg::khs_supply_s i_supply, // Supply monitor pins
  output logic o_power_fail_warning_pin_n, // Low on power fail
  output khs_pkg::khs_feat_s o_feat, // Active features
  output logic [15:0] o_phys_addr, // Stored own address
  output khs_pkg::khs_op_e o_op_state, // Operating state
  output logic o_busmon, // Bus monitor state
  output logic [3:0] o_poll_slot, // Poll slot number
  output logic [15:0] o_poll_addr, // Poll address
  output logic [7:0] o_poll_state, // Poll state byte
  output logic o_ireg_wr, // Internal register write
  output logic o_ireg_rd, // Internal register read
  output logic [1:0] o_ireg_addr, // Internal register address
  output logic [7:0] o_ireg_wdata, // Internal register data
  input wire logic [7:0] i_ireg_rdata, // Internal register value
  input wire logic [2:0] i_reg_addr, // Register port address
  input wire logic [7:0] i_reg_wdata, // Register port data
  input wire logic i_reg_wr, // Register write strobe
  input wire logic i_reg_rd, // Register read strobe
  output logic [7:0] o_reg_rdata // Read data, next cycle
);
  import khs_pkg::*;

  khs_ps_e ps_r;
  khs_op_e op_r, op_nxt;
  khs_rt_e rt_r;
  khs_feat_s feat_r;
  khs_supply_s sup_m_r, sup_s_r;
  logic [15:0] phys_r, addr_new_r;
  logic addr_pend_r, cfg_pend_r, busmon_r;
  logic [2:0] cfg_req_r, lim_b_r, lim_n_r, try_b_r, try_n_r;
  logic [7:0] bus_byte_r, fst_r, rd_r;
  logic [15:0] crc_r, crc_out_r;
  logic [`KHS_NSRC-1:0] pend_r, pend_set, gnt;
  logic [7:0] src [`KHS_NSRC];
  logic [7:0] sel_byte;
  logic [7:0] bt_r, need_r;
  logic con_pos_r, rd_wait_r, addressed_r, sil_arm_r;
  logic [31:0] sil_r;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {d, 8'h00};
    for (int k = 0; k < 8; k++) begin
      r = r[15] ? ((r << 1) ^ `KHS_CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // Command decode
  wire rx_cmd = i_rx.vld && ps_r == PS_CMD;
  wire c_reset = rx_cmd && i_rx.dat == `KHS_CMD_RESET;
  wire c_busmon = rx_cmd && i_rx.dat == `KHS_CMD_BUSMON;
  wire c_sys = rx_cmd && i_rx.dat == `KHS_CMD_SYSSTAT;
  wire c_stop = rx_cmd && i_rx.dat == `KHS_CMD_STOP;
  wire c_exit = rx_cmd && i_rx.dat == `KHS_CMD_EXITSTOP;
  wire c_setbusy = rx_cmd && i_rx.dat == `KHS_CMD_SETBUSY;
  wire c_quitbusy = rx_cmd && i_rx.dat == `KHS_CMD_QUITBUSY;
  wire c_addr = rx_cmd && i_rx.dat == `KHS_CMD_SETADDR;
  wire c_rep = rx_cmd && i_rx.dat == `KHS_CMD_SETREP;
  wire c_cfg = rx_cmd && (i_rx.dat & `KHS_MASK_CFG) == `KHS_CMD_CFG;
  wire c_regwr = rx_cmd && (i_rx.dat & `KHS_MASK_REG) == `KHS_CMD_REGWR;
  wire c_regrd = rx_cmd && (i_rx.dat & `KHS_MASK_REG) == `KHS_CMD_REGRD;
  wire c_poll = rx_cmd && (i_rx.dat & `KHS_MASK_POLL) == `KHS_CMD_POLL;
  wire addr_done = i_rx.vld && ps_r == PS_FILL;
  wire rep_done = i_rx.vld && ps_r == PS_REP;
  wire addr_apply = addr_pend_r && i_bus_idle;
  wire cfg_apply = cfg_pend_r && (i_bus_idle || op_r != OP_NORMAL);
  wire reg_lim_wr = i_reg_wr && i_reg_addr == `KHS_REG_LIMITS;

  // Status byte and supply health
  wire supply_ok = sup_s_r.v20 & sup_s_r.converter_two_ok & sup_s_r.bus_voltage_ok & sup_s_r.tank_cap_ok & sup_s_r.crystal_ok;
  wire [7:0] stat = {sup_s_r, op_r};
  wire pfw_n = &stat[`KHS_ST_OK] & ~stat[`KHS_ST_TW];

  // Bus byte forwarding
  wire bus_fwd = i_bus.vld && (busmon_r || !i_bus_is_ack);
  wire dst_hit = i_dst_group || i_dst_addr == phys_r;

  // Retry handling
  wire ack_to = rt_r == R_WACK && i_bit_tick && bt_r == `KHS_ACK_TO_BT - 8'h01;
  wire ack_in = rt_r == R_WACK && (i_ack_valid || ack_to);
  wire ack_busy = i_ack_valid && i_ack_kind == ACK_BUSY;
  wire ack_pos = i_ack_valid && i_ack_kind == ACK_POS;
  wire busy_more = try_b_r < lim_b_r;
  wire nack_more = try_n_r < lim_n_r;
  wire retry_b = ack_in && !ack_pos && ack_busy && busy_more;
  wire retry_n = ack_in && !ack_pos && !ack_busy && nack_more;
  wire con_fire = ack_in && !retry_b && !retry_n;
  wire retx_fire = rt_r == R_WIDLE && i_bus_idle && bt_r >= need_r;

  // Outgoing byte selection
  wire tx_free = !o_tx.vld || i_tx_ready;
  wire frame_busy = pend_r[`KHS_SRC_BUS] | pend_r[`KHS_SRC_DUP] | pend_r[`KHS_SRC_CRCH]
                  | pend_r[`KHS_SRC_CRCL] | pend_r[`KHS_SRC_FEND] | pend_r[`KHS_SRC_FST];
  wire sil_load = sil_arm_r && !frame_busy && !o_tx.vld;
  wire tx_go = tx_free && sil_r == 32'h0000_0000 && !sil_load;

  assign src[`KHS_SRC_BUS] = bus_byte_r;
  assign src[`KHS_SRC_DUP] = `KHS_IND_FEND;
  assign src[`KHS_SRC_CRCH] = crc_out_r[15:8];
  assign src[`KHS_SRC_CRCL] = crc_out_r[7:0];
  assign src[`KHS_SRC_FEND] = `KHS_IND_FEND;
  assign src[`KHS_SRC_FST] = fst_r;
  assign src[`KHS_SRC_CON] = {con_pos_r, `KHS_CON_TAIL};
  assign src[`KHS_SRC_CFG] = {1'b0, feat_r, `KHS_CFG_TAIL};
  assign src[`KHS_SRC_SYS1] = `KHS_IND_SYS;
  assign src[`KHS_SRC_SYS2] = stat;
  assign src[`KHS_SRC_STOP] = `KHS_IND_STOP;
  assign src[`KHS_SRC_RST] = `KHS_IND_RESET;
  assign src[`KHS_SRC_RD] = rd_r;

  assign pend_set[`KHS_SRC_BUS] = bus_fwd;
  assign pend_set[`KHS_SRC_DUP] = bus_fwd && feat_r.mark && i_bus.dat == `KHS_IND_FEND;
  assign pend_set[`KHS_SRC_CRCH] = i_frame_end && feat_r.crc && !busmon_r;
  assign pend_set[`KHS_SRC_CRCL] = i_frame_end && feat_r.crc && !busmon_r;
  assign pend_set[`KHS_SRC_FEND] = i_frame_end && feat_r.mark && !busmon_r;
  assign pend_set[`KHS_SRC_FST] = i_frame_end && feat_r.mark && !busmon_r;
  assign pend_set[`KHS_SRC_CON] = con_fire;
  assign pend_set[`KHS_SRC_CFG] = (addr_apply && !feat_r.aa) || cfg_apply;
  assign pend_set[`KHS_SRC_SYS1] = c_sys;
  assign pend_set[`KHS_SRC_SYS2] = c_sys;
  assign pend_set[`KHS_SRC_STOP] = op_nxt == OP_STOP && op_r != OP_STOP;
  assign pend_set[`KHS_SRC_RST] = op_nxt == OP_NORMAL && op_r != OP_NORMAL;
  assign pend_set[`KHS_SRC_RD] = rd_wait_r;

  always_comb begin
    gnt = '0;
    sel_byte = 8'h00;
    for (int i = `KHS_NSRC - 1; i >= 0; i--) begin
      if (tx_go && pend_r[i]) begin
        gnt = '0;
        gnt[i] = 1'b1;
        sel_byte = src[i];
      end
    end
  end

  // Operating state
  always_comb begin
    op_nxt = op_r;
    case (op_r)
      OP_PWRUP: if (supply_ok) op_nxt = OP_SYNC;
      OP_SYNC: if (i_sync_done) op_nxt = OP_NORMAL;
      OP_STOP: if (c_exit) op_nxt = OP_SYNC;
      OP_NORMAL: if (!sup_s_r.bus_voltage_ok) op_nxt = OP_PWRUP;
      default: op_nxt = OP_PWRUP;
    endcase
    if (c_stop) op_nxt = OP_STOP;
    if (c_reset) op_nxt = OP_PWRUP;
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      op_r <= OP_PWRUP;
      sup_m_r <= '0;
      sup_s_r <= '0;
      o_power_fail_warning_pin_n <= 1'b0;
    end else if (i_ce) begin
      op_r <= op_nxt;
      sup_m_r <= i_supply;
      sup_s_r <= sup_m_r;
      o_power_fail_warning_pin_n <= pfw_n;
    end
  end

  // Host command parser
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      ps_r <= PS_CMD;
      addr_new_r <= 16'h0000;
      o_poll_slot <= 4'h0;
      o_poll_addr <= 16'h0000;
      o_poll_state <= 8'h00;
      o_ireg_wr <= 1'b0;
      o_ireg_rd <= 1'b0;
      o_ireg_addr <= 2'h0;
      o_ireg_wdata <= 8'h00;
      rd_wait_r <= 1'b0;
      rd_r <= 8'h00;
    end else if (i_ce) begin
      o_ireg_wr <= 1'b0;
      o_ireg_rd <= c_regrd;
      rd_wait_r <= o_ireg_rd;
      if (rd_wait_r) rd_r <= i_ireg_rdata;
      if (c_regrd || c_regwr) o_ireg_addr <= i_rx.dat[1:0];
      if (i_rx.vld) begin
        case (ps_r)
          PS_CMD: begin
            if (c_addr) ps_r <= PS_AHI;
            if (c_rep) ps_r <= PS_REP;
            if (c_regwr) ps_r <= PS_WDAT;
            if (c_poll) begin
              ps_r <= PS_PAHI;
              o_poll_slot <= i_rx.dat[3:0];
            end
          end
          PS_AHI: begin
            addr_new_r[15:8] <= i_rx.dat;
            ps_r <= PS_ALO;
          end
          PS_ALO: begin
            addr_new_r[7:0] <= i_rx.dat;
            ps_r <= PS_FILL;
          end
          PS_WDAT: begin
            o_ireg_wdata <= i_rx.dat;
            o_ireg_wr <= 1'b1;
            ps_r <= PS_CMD;
          end
          PS_PAHI: begin
            o_poll_addr[15:8] <= i_rx.dat;
            ps_r <= PS_PALO;
          end
          PS_PALO: begin
            o_poll_addr[7:0] <= i_rx.dat;
            ps_r <= PS_PST;
          end
          PS_PST: begin
            o_poll_state <= i_rx.dat;
            ps_r <= PS_CMD;
          end
          default: ps_r <= PS_CMD; // Filler, limits
        endcase
      end
    end
  end

  // Features and limits
  always_ff @(posedge i_mclk) begin
    if (i_rst || (i_ce && c_reset)) begin
      feat_r <= '0;
      busmon_r <= 1'b0;
      phys_r <= 16'h0000;
      addr_pend_r <= 1'b0;
      cfg_pend_r <= 1'b0;
      cfg_req_r <= 3'h0;
      lim_b_r <= `KHS_LIM_RST;
      lim_n_r <= `KHS_LIM_RST;
    end else if (i_ce) begin
      if (c_setbusy && feat_r.aa) feat_r.busy <= 1'b1;
      if (c_quitbusy) feat_r.busy <= 1'b0;
      if (c_busmon) busmon_r <= 1'b1;
      if (addr_apply) begin
        phys_r <= addr_new_r;
        feat_r.aa <= 1'b1;
        addr_pend_r <= 1'b0;
      end
      if (addr_done) addr_pend_r <= 1'b1;
      if (cfg_apply) begin
        feat_r.ap <= feat_r.ap | cfg_req_r[`KHS_CFG_P];
        feat_r.crc <= feat_r.crc | cfg_req_r[`KHS_CFG_C];
        feat_r.mark <= feat_r.mark | cfg_req_r[`KHS_CFG_M];
        cfg_pend_r <= 1'b0;
      end
      if (c_cfg) begin
        cfg_req_r <= i_rx.dat[2:0];
        cfg_pend_r <= 1'b1;
      end
      if (rep_done) begin
        lim_b_r <= i_rx.dat[`KHS_REP_BSY];
        lim_n_r <= i_rx.dat[`KHS_REP_NAK];
      end else if (reg_lim_wr) begin
        lim_b_r <= i_reg_wdata[`KHS_REP_BSY];
        lim_n_r <= i_reg_wdata[`KHS_REP_NAK];
      end
    end
  end

  // Received frames
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      bus_byte_r <= 8'h00;
      crc_r <= `KHS_CRC_INIT;
      crc_out_r <= 16'h0000;
      fst_r <= 8'h00;
      addressed_r <= 1'b0;
      o_ack_req <= 1'b0;
      o_ack_code <= ACK_POS;
    end else if (i_ce) begin
      o_ack_req <= 1'b0;
      if (bus_fwd) begin
        bus_byte_r <= i_bus.dat;
        crc_r <= crc_step(crc_r, i_bus.dat);
      end
      if (i_dst_valid) addressed_r <= dst_hit;
      if (i_frame_end) begin
        crc_out_r <= crc_r;
        crc_r <= `KHS_CRC_INIT;
        fst_r <= {i_ferr, `KHS_FST_TAIL};
        addressed_r <= 1'b0;
        if (feat_r.aa && addressed_r && !busmon_r) begin
          o_ack_req <= 1'b1;
          if (feat_r.busy) o_ack_code <= ACK_BUSY;
          else if (|i_ferr) o_ack_code <= ACK_NACK;
          else o_ack_code <= ACK_POS;
        end
      end
    end
  end

  // Own frame retransmission
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      rt_r <= R_IDLE;
      bt_r <= 8'h00;
      need_r <= 8'h00;
      try_b_r <= 3'h0;
      try_n_r <= 3'h0;
      con_pos_r <= 1'b0;
      o_retx_req <= 1'b0;
    end else if (i_ce) begin
      o_retx_req <= 1'b0;
      if (i_new_frame) begin
        try_b_r <= 3'h0;
        try_n_r <= 3'h0;
      end
      case (rt_r)
        R_IDLE: if (i_txf_done) begin
          rt_r <= R_WACK;
          bt_r <= 8'h00;
        end
        R_WACK: begin
          if (i_bit_tick) bt_r <= bt_r + 8'h01;
          if (ack_in) begin
            bt_r <= 8'h00;
            rt_r <= (retry_b || retry_n) ? R_WIDLE : R_IDLE;
            con_pos_r <= ack_pos;
          end
          if (retry_b) begin
            try_b_r <= try_b_r + 3'h1;
            need_r <= `KHS_BUSY_IDLE_BT;
          end
          if (retry_n) begin
            try_n_r <= try_n_r + 3'h1;
            need_r <= `KHS_NACK_IDLE_BT;
          end
        end
        R_WIDLE: begin
          if (!i_bus_idle) bt_r <= 8'h00;
          else if (i_bit_tick && bt_r < need_r) bt_r <= bt_r + 8'h01;
          if (retx_fire) begin
            o_retx_req <= 1'b1;
            rt_r <= R_IDLE;
          end
        end
        default: rt_r <= R_IDLE;
      endcase
    end
  end

  // Byte stream to host
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      pend_r <= '0;
      o_tx <= '0;
      sil_arm_r <= 1'b0;
      sil_r <= 32'h0000_0000;
    end else if (i_ce) begin
      pend_r <= (pend_r & ~gnt) | pend_set;
      if (|gnt) o_tx <= {1'b1, sel_byte};
      else if (i_tx_ready) o_tx.vld <= 1'b0;
      if (sil_load) begin
        sil_r <= 32'(SILENCE_CYC);
        sil_arm_r <= 1'b0;
      end else if (sil_r != 32'h0000_0000) begin
        sil_r <= sil_r - 32'h0000_0001;
      end
      if (i_frame_end && !feat_r.mark && !busmon_r) sil_arm_r <= 1'b1;
      if (c_reset) pend_r <= '0;
    end
  end

  // Register port
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_reg_rdata <= 8'h00;
      o_feat <= '0;
      o_phys_addr <= 16'h0000;
      o_op_state <= OP_PWRUP;
      o_busmon <= 1'b0;
    end else if (i_ce) begin
      o_feat <= feat_r;
      o_phys_addr <= phys_r;
      o_op_state <= op_r;
      o_busmon <= busmon_r;
      o_reg_rdata <= 8'h00;
      if (i_reg_rd) begin
        case (i_reg_addr)
          `KHS_REG_STATUS: o_reg_rdata <= {1'b0, feat_r, op_r};
          `KHS_REG_LIMITS: o_reg_rdata <= {1'b0, lim_b_r, 1'b0, lim_n_r};
          `KHS_REG_PHYS_HI: o_reg_rdata <= phys_r[15:8];
          `KHS_REG_PHYS_LO: o_reg_rdata <= phys_r[7:0];
          default: o_reg_rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/khs_host_ctrl_asserts.sv ***
`include "khs_cfg.svh"
`default_nettype none
module khs_host_ctrl_asserts (
  input wire logic i_mclk, // Clock
  input wire logic i_rst, // Reset
  input wire khs_pkg::khs_byte_s i_rx, // Host byte
  input wire khs_pkg::khs_ferr_s i_ferr, // Frame errors
  input wire logic i_bus_idle, // Bus idle
  input wire khs_pkg::khs_supply_s i_supply, // Supply flags
  input wire logic o_ack_req, // Ack request
  input wire khs_pkg::khs_ack_e o_ack_code, // Ack code
  input wire logic o_power_fail_warning_pin_n, // Warning pin
  input wire khs_pkg::khs_feat_s o_feat, // Features
  input wire khs_pkg::khs_op_e o_op_state, // State
  input wire logic o_busmon // Monitor state
);
  import khs_pkg::*;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  logic [3:0] rcmd_r; // Reset requests seen lately
  wire logic rcmd = i_rx.vld && i_rx.dat == `KHS_CMD_RESET;
  always_ff @(posedge i_mclk) rcmd_r <= i_rst ? 4'h0 : {rcmd_r[2:0], rcmd};
  sequence s_cmd(logic [7:0] c);
    i_rx.vld && i_rx.dat == c;
  endsequence
  sequence s_addr;
    s_cmd(`KHS_CMD_SETADDR) ##1 i_rx.vld [*3];
  endsequence
  property p_pfw;
    $stable(i_supply) [*5] |-> o_power_fail_warning_pin_n == (&i_supply[5:1] && !i_supply.tw);
  endproperty
  a_pfw: assert property (p_pfw) else $error("warning pin wrong");
  property p_feat_keep;
    |($past(o_feat[3:0]) & ~o_feat[3:0]) |-> |rcmd_r;
  endproperty
  a_feat_keep: assert property (p_feat_keep) else $error("feature dropped");
  property p_mon_keep;
    $fell(o_busmon) |-> |rcmd_r;
  endproperty
  a_mon_keep: assert property (p_mon_keep) else $error("monitor left");
  property p_quit;
    s_cmd(`KHS_CMD_QUITBUSY) |-> ##[1:3] !o_feat.busy;
  endproperty
  a_quit: assert property (p_quit) else $error("busy kept");
  property p_ack_err;
    o_ack_req && $past(|i_ferr) && !$past(o_feat.busy, 2) |-> o_ack_code == ACK_NACK;
  endproperty
  a_ack_err: assert property (p_ack_err) else $error("errored frame acked");
  property p_stop;
    s_cmd(`KHS_CMD_STOP) |-> ##[1:4] o_op_state == OP_STOP;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not entered");
  property p_exit;
    s_cmd(`KHS_CMD_EXITSTOP) ##0 o_op_state == OP_STOP |-> ##[1:4] o_op_state == OP_SYNC;
  endproperty
  a_exit: assert property (p_exit) else $error("sync not entered");
  property p_aa_idle;
    $rose(o_feat.aa) |-> $past(i_bus_idle) || $past(i_bus_idle, 2) || $past(i_bus_idle, 3);
  endproperty
  a_aa_idle: assert property (p_aa_idle) else $error("auto ack on busy bus");
  property p_addr;
    s_addr ##1 i_bus_idle [*2] |-> ##[0:4] o_feat.aa;
  endproperty
  a_addr: assert property (p_addr) else $error("auto ack not enabled");
endmodule
`default_nettype wire

// *** tb/khs_host_model.sv ***
`default_nettype none
module khs_host_model (
  input wire logic i_mclk, // Clock
  input wire logic i_rst, // Reset
  input wire khs_pkg::khs_byte_s i_tx, // Byte from device
  output logic o_ready // Byte taken
);
  timeunit 1ns;
  timeprecision 1ns;
  import khs_pkg::*;
  logic [7:0] got[$]; // Bytes taken
  logic [1:0] cnt_r; // Stall pattern
  always @(posedge i_mclk) begin
    if (i_tx.vld && o_ready) got.push_back(i_tx.dat);
    cnt_r <= i_rst ? 2'h0 : cnt_r + 2'h1;
  end
  // Stalls one cycle in four
  assign o_ready = cnt_r != 2'h3;
endmodule
`default_nettype wire

// *** tb/test_knx_host_service_control.sv ***
`include "khs_cfg.svh"
`default_nettype none
module test_knx_host_service_control;
  timeunit 1ns;
  timeprecision 1ns;
  import khs_pkg::*;
  logic i_mclk = 0, i_rst = 1, i_tx_ready, i_bus_is_ack = 0, i_frame_end = 0, i_dst_valid = 0;
  logic i_bus_idle = 1, i_bit_tick = 0, i_new_frame = 0, i_txf_done = 0, i_ack_valid = 0;
  logic i_reg_wr = 0, i_reg_rd = 0, o_retx_req, o_ack_req, o_power_fail_warning_pin_n, o_busmon;
  logic [15:0] i_dst_addr = 0, o_phys_addr;
  logic [7:0] i_reg_wdata = 0, o_reg_rdata;
  logic [2:0] i_reg_addr = 0;
  khs_byte_s i_rx = 0, i_bus = 0, o_tx;
  khs_ferr_s i_ferr = 0;
  khs_supply_s i_supply = 0;
  khs_ack_e i_ack_kind = ACK_POS, o_ack_code;
  khs_feat_s o_feat;
  khs_op_e o_op_state;
  int err_count = 0, total_checks = 0, n;
  initial forever #20 i_mclk = ~i_mclk;
  always @(posedge i_mclk) i_bit_tick <= ~i_bit_tick;
  khs_host_ctrl #(.SILENCE_CYC(20)) khs_host_ctrl_inst (.i_mclk, .i_rst, .i_ce(1'b1), .i_rx, .o_tx, .i_tx_ready,
    .i_bus, .i_bus_is_ack, .i_frame_end, .i_ferr, .i_dst_valid, .i_dst_addr, .i_dst_group(1'b0), .i_bus_idle,
    .i_bit_tick, .i_sync_done(1'b0), .i_new_frame, .i_txf_done, .i_ack_valid, .i_ack_kind, .o_retx_req,
    .o_ack_req, .o_ack_code, .i_supply, .o_power_fail_warning_pin_n, .o_feat, .o_phys_addr, .o_op_state,
    .o_busmon, .o_poll_slot(), .o_poll_addr(), .o_poll_state(), .o_ireg_wr(), .o_ireg_rd(), .o_ireg_addr(),
    .o_ireg_wdata(), .i_ireg_rdata(8'h5A), .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata);
  khs_host_model khs_host_model_inst (.i_mclk, .i_rst, .i_tx(o_tx), .o_ready(i_tx_ready));
  task automatic print_verdict();
    $display("Checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check(string what, logic [15:0] seen, logic [15:0] want);
    total_checks++;
    if (seen !== want) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic wait_hi(ref logic s, input int lim, output int k);
    for (k = 0; k < lim; k++) begin
      @(negedge i_mclk);
      if (s === 1'b1) break;
    end
    if (k == lim) begin
      err_count++;
      $display("Error wait expected 1 seen %b", s);
      print_verdict();
    end
    @(posedge i_mclk);
  endtask
  task automatic send(input logic [7:0] b[$]);
    foreach (b[k]) begin
      i_rx <= {1'b1, b[k]};
      @(posedge i_mclk);
    end
    i_rx <= '0;
    @(posedge i_mclk);
  endtask
  task automatic expect_tx(input logic [7:0] e[$]);
    foreach (e[k]) begin
      for (int m = 0; m < 400 && khs_host_model_inst.got.size() == 0; m++) @(posedge i_mclk);
      if (khs_host_model_inst.got.size() == 0) begin
        err_count++;
        $display("Error host byte expected %h seen none", e[k]);
        print_verdict();
      end
      check("host byte", 16'(khs_host_model_inst.got.pop_front()), 16'(e[k]));
    end
  endtask
  task automatic reg_rd(logic [2:0] a, logic [7:0] want);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_mclk);
    i_reg_rd <= 1'b0;
    @(negedge i_mclk);
    check("reg read", 16'(o_reg_rdata), 16'(want));
    @(posedge i_mclk);
  endtask
  task automatic frame(khs_ferr_s fe, khs_ack_e code, logic [7:0] fst);
    i_bus <= {1'b1, 8'hB0};
    i_dst_valid <= 1'b1;
    i_dst_addr <= 16'h5678;
    @(posedge i_mclk);
    i_bus <= '0;
    i_dst_valid <= 1'b0;
    @(posedge i_mclk);
    i_frame_end <= 1'b1;
    i_ferr <= fe;
    @(posedge i_mclk);
    i_frame_end <= 1'b0;
    i_ferr <= '0;
    wait_hi(o_ack_req, 4, n);
    check("ack code", 16'(o_ack_code), 16'(code));
    expect_tx({8'hB0, 8'h46, 8'h2B, `KHS_IND_FEND, fst});
  endtask
  task automatic attempt(logic nf, khs_ack_e k);
    i_new_frame <= nf;
    i_txf_done <= 1'b1;
    @(posedge i_mclk);
    i_new_frame <= 1'b0;
    i_txf_done <= 1'b0;
    i_ack_valid <= 1'b1;
    i_ack_kind <= k;
    @(posedge i_mclk);
    i_ack_valid <= 1'b0;
  endtask
  initial begin
    repeat (20) @(posedge i_mclk);
    i_rst <= 1'b0;
    @(posedge i_mclk);
    check("warning pin", 16'(o_power_fail_warning_pin_n), 16'h0);
    reg_rd(3'h1, 8'h33);
    reg_rd(3'h5, 8'h00);
    i_supply <= 6'b111110;
    repeat (6) @(posedge i_mclk);
    check("warning pin", 16'(o_power_fail_warning_pin_n), 16'h1);
    send({`KHS_CMD_SYSSTAT});
    expect_tx({`KHS_IND_SYS, 8'hF9});
    send({`KHS_CMD_CFG | 8'h07});
    expect_tx({8'h1D});
    send({`KHS_CMD_CFG});
    expect_tx({8'h1D});
    check("features", 16'(o_feat), 16'h0007);
    i_bus_idle <= 1'b0;
    send({`KHS_CMD_SETADDR, 8'h12, 8'h34, 8'h9C});
    repeat (8) @(posedge i_mclk);
    check("auto ack early", 16'(o_feat.aa), 16'h0);
    i_bus_idle <= 1'b1;
    expect_tx({8'h3D});
    check("address", o_phys_addr, 16'h1234);
    send({`KHS_CMD_SETADDR, 8'h56, 8'h78, 8'hFF});
    repeat (6) @(posedge i_mclk);
    check("address", o_phys_addr, 16'h5678);
    check("extra report", 16'(khs_host_model_inst.got.size()), 16'h0);
    frame('0, ACK_POS, 8'h13);
    frame(3'b100, ACK_NACK, 8'h93);
    send({`KHS_CMD_SETBUSY});
    frame('0, ACK_BUSY, 8'h13);
    send({`KHS_CMD_QUITBUSY});
    frame('0, ACK_POS, 8'h13);
    i_reg_addr <= 3'h1;
    i_reg_wdata <= 8'h77;
    i_reg_wr <= 1'b1;
    @(posedge i_mclk);
    i_reg_wr <= 1'b0;
    reg_rd(3'h1, 8'h77);
    send({`KHS_CMD_SETREP, 8'h10});
    reg_rd(3'h1, 8'h10);
    attempt(1'b1, ACK_BUSY);
    wait_hi(o_retx_req, 400, n);
    check("retry wait", 16'(n > 290), 16'h1);
    attempt(1'b0, ACK_BUSY);
    expect_tx({8'h0B});
    attempt(1'b1, ACK_NACK);
    expect_tx({8'h0B});
    attempt(1'b1, ACK_POS);
    expect_tx({8'h8B});
    send({`KHS_CMD_STOP});
    expect_tx({`KHS_IND_STOP});
    check("state", 16'(o_op_state), 16'(OP_STOP));
    send({`KHS_CMD_SYSSTAT});
    expect_tx({`KHS_IND_SYS, 8'hFA});
    send({`KHS_CMD_REGRD | 8'h01});
    expect_tx({8'h5A});
    send({`KHS_CMD_EXITSTOP});
    repeat (4) @(posedge i_mclk);
    check("state", 16'(o_op_state), 16'(OP_SYNC));
    send({`KHS_CMD_BUSMON});
    i_bus <= {1'b1, 8'hCC};
    i_bus_is_ack <= 1'b1;
    @(posedge i_mclk);
    i_bus <= '0;
    i_bus_is_ack <= 1'b0;
    expect_tx({8'hCC});
    send({`KHS_CMD_RESET});
    repeat (4) @(posedge i_mclk);
    check("monitor", 16'(o_busmon), 16'h0);
    check("features", 16'(o_feat), 16'h0);
    i_supply <= 6'b111111;
    repeat (6) @(posedge i_mclk);
    check("warning pin", 16'(o_power_fail_warning_pin_n), 16'h0);
    print_verdict();
  end
endmodule
bind khs_host_ctrl khs_host_ctrl_asserts khs_host_ctrl_asserts_inst (.i_mclk, .i_rst, .i_rx, .i_ferr, .i_bus_idle,
  .i_supply, .o_ack_req, .o_ack_code, .o_power_fail_warning_pin_n, .o_feat, .o_op_state, .o_busmon);
`default_nettype wire
